// ==== hdl/ialc_top.sv ====
// Purpose: ingress access list classifier, one verdict per frame descriptor
// Assumes: parsed frame fields arrive as one-cycle descriptors on i_clk
// Notes: verdict appears on the edge that takes the descriptor; APB answers
//        in the second access cycle
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/10ps
`default_nettype none
module ialc_top
    import ialc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_frm_valid,
    input wire logic [2:0] i_frm_port,
    input wire logic [3:0] i_frm_policy,
    input wire logic [15:0] i_frm_ethtype,
    input wire logic [47:0] i_frm_source_hw_address_filter,
    input wire logic [47:0] i_frm_dest_hw_address_filter,
    input wire logic [11:0] i_frm_vid,
    input wire logic [2:0] i_frm_pcp,
    input wire logic [7:0] i_frm_proto,
    input wire logic [7:0] i_frm_ttl,
    output logic o_vrd_valid,
    output logic o_vrd_hit,
    output logic [2:0] o_vrd_entry,
    output logic o_vrd_permit,
    output logic o_vrd_use_default,
    output logic [3:0] o_vrd_rate_lim,
    output logic o_vrd_copy,
    output logic [2:0] o_vrd_copy_port,
    output logic o_vrd_log,
    output logic [2:0] o_vrd_port,
    output logic [7:0] o_port_disable
);
    import ialc_pkg::*;

    logic [31:0] ctrl0 [NUM_ENTRIES];
    logic [31:0] ctrl1 [NUM_ENTRIES];
    logic [47:0] source_hw_address_filter [NUM_ENTRIES];
    logic [47:0] dest_hw_address_filter [NUM_ENTRIES];
    logic [31:0] hit_count [NUM_ENTRIES];
    logic [3:0] list_len;
    logic [NUM_ENTRIES-1:0] hit;
    logic any_hit;
    logic [2:0] first_idx;
    logic [31:0] first_c0;
    logic apb_acc;
    logic apb_wr;
    logic is_ent;
    logic [2:0] ent_idx;
    logic [2:0] ent_word;
    logic mapped;
    logic [31:0] rd_word;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    ////////////////////////////////////////////////////////////////////////
    // entry compare: one call per list slot
    function automatic logic ialc_match(
        input logic [31:0] c0,
        input logic [31:0] c1,
        input logic [47:0] sm,
        input logic [47:0] dm,
        input logic [2:0] port,
        input logic [3:0] pol,
        input logic [15:0] et,
        input logic [47:0] fs,
        input logic [47:0] fd,
        input logic [11:0] vid,
        input logic [2:0] pcp,
        input logic [7:0] pro,
        input logic [7:0] ttl);
        logic is_arp;
        logic is_ip;
        logic ing;
        logic ft;
        logic smok;
        logic dmok;
        logic prok;
        logic tok;
        logic [1:0] ftype;
        logic [1:0] imode;
        is_arp = (et == ETYPE_ARP);
        is_ip = (et == ETYPE_IPV4);
        ftype = c0[F_FTYPE +: 2];
        imode = c0[F_ING_MODE +: 2];
        // out-of-range policy numbers never match a policy entry
        ing = (imode == ING_ANY) ||
              ((imode == ING_PORT) && ({1'b0, port} == c0[F_ING_VAL +: 4])) ||
              ((imode == ING_POLICY) && (pol == c0[F_ING_VAL +: 4]) &&
               (pol >= POLICY_MIN) && (pol <= POLICY_MAX));
        case (ftype)
            FT_ANY: ft = 1'b1;
            FT_ETYPE: ft = (et >= ETYPE_MIN) && !is_arp && !is_ip;
            FT_ARP: ft = is_arp;
            default: ft = is_ip;
        endcase
        // source filter is ignored for any and IPv4 entries
        smok = !c0[F_SOURCE_HW_ADDRESS_FILTER_SPEC] || !((ftype == FT_ETYPE) || (ftype == FT_ARP)) ||
               (fs == sm);
        case (c0[F_DEST_HW_ADDRESS_FILTER_MODE +: 3])
            DM_ANY: dmok = 1'b1;
            DM_GROUP: dmok = fd[40] && !(&fd);
            DM_ALL_ONES: dmok = &fd;
            DM_SINGLE: dmok = !fd[40];
            DM_EXACT: dmok = (fd == dm);
            default: dmok = 1'b0;
        endcase
        case (c1[F_PROTO_MODE +: 3])
            PR_ANY: prok = 1'b1;
            PR_SPEC: prok = (pro == c1[F_PROTO +: 8]);
            PR_ICMP: prok = (pro == PROTO_ICMP);
            PR_UDP: prok = (pro == PROTO_UDP);
            PR_TCP: prok = (pro == PROTO_TCP);
            default: prok = 1'b0;
        endcase
        case (c1[F_TTL_MODE +: 2])
            TTL_ZERO: tok = (ttl == 8'h00);
            TTL_NONZERO: tok = (ttl != 8'h00);
            default: tok = 1'b1;
        endcase
        // protocol and ttl fields only exist for IPv4 entries
        if (ftype != FT_IPV4) begin
            prok = 1'b1;
            tok = 1'b1;
        end
        return ing && ft && smok && dmok && prok && tok &&
               (!c1[F_VID_SPEC] || (vid == c1[F_VID +: 12])) &&
               (!c1[F_PRI_SPEC] || (pcp == c1[F_PRI +: 3]));
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // slots beyond the list length never match, so length 0 matches nothing
    for (genvar i = 0; i < NUM_ENTRIES; i++) begin : g_slot
        assign hit[i] = (4'(i) < list_len) &&
            ialc_match(ctrl0[i], ctrl1[i], source_hw_address_filter[i], dest_hw_address_filter[i], i_frm_port, i_frm_policy,
                       i_frm_ethtype, i_frm_source_hw_address_filter, i_frm_dest_hw_address_filter, i_frm_vid, i_frm_pcp,
                       i_frm_proto, i_frm_ttl);
    end

    // lowest matching slot wins; scan downward so the last write is the first hit
    always_comb begin
        first_idx = 3'h0;
        for (int k = NUM_ENTRIES - 1; k >= 0; k--) begin
            if (hit[k]) begin
                first_idx = 3'(k);
            end
        end
        any_hit = |hit;
        first_c0 = ctrl0[first_idx];
    end

    ////////////////////////////////////////////////////////////////////////
    // verdict to forwarding; actions are zero when the port default applies
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_vrd_valid <= 1'b0;
            o_vrd_hit <= 1'b0;
            o_vrd_entry <= 3'h0;
            o_vrd_permit <= 1'b0;
            o_vrd_use_default <= 1'b0;
            o_vrd_rate_lim <= 4'h0;
            o_vrd_copy <= 1'b0;
            o_vrd_copy_port <= 3'h0;
            o_vrd_log <= 1'b0;
            o_vrd_port <= 3'h0;
        end else begin
            o_vrd_valid <= i_frm_valid;
            if (i_frm_valid) begin
                o_vrd_hit <= any_hit;
                o_vrd_entry <= first_idx;
                o_vrd_port <= i_frm_port;
                o_vrd_use_default <= !any_hit;
                o_vrd_permit <= any_hit && !first_c0[F_DENY];
                o_vrd_rate_lim <= any_hit ? first_c0[F_RATE +: 4] : 4'h0;
                o_vrd_copy <= any_hit && first_c0[F_COPY_EN];
                o_vrd_copy_port <= any_hit ? first_c0[F_COPY_PORT +: 3] : 3'h0;
                o_vrd_log <= any_hit && first_c0[F_LOG];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // port shutdown mask: a new shutdown hit wins over a software clear
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_port_disable <= 8'h00;
        end else begin
            for (int p = 0; p < 8; p++) begin
                if (i_frm_valid && any_hit && first_c0[F_SHUT] && (i_frm_port == 3'(p))) begin
                    o_port_disable[p] <= 1'b1;
                end else if (apb_wr && (i_paddr == A_SHUT) && i_pwdata[p]) begin
                    o_port_disable[p] <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // hit counters wrap; a write clears, but a hit in that cycle leaves one
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int e = 0; e < NUM_ENTRIES; e++) begin
                hit_count[e] <= 32'h0000_0000;
            end
        end else begin
            for (int e = 0; e < NUM_ENTRIES; e++) begin
                if (apb_wr && is_ent && (ent_idx == 3'(e)) && (ent_word == W_COUNT)) begin
                    hit_count[e] <= (i_frm_valid && any_hit && (first_idx == 3'(e))) ?
                                    32'h0000_0001 : 32'h0000_0000;
                end else if (i_frm_valid && any_hit && (first_idx == 3'(e))) begin
                    hit_count[e] <= hit_count[e] + 32'h0000_0001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB decode; write lands on the edge that samples pready high
    assign apb_acc = i_psel && i_penable;
    assign apb_wr = apb_acc && o_pready && i_pwrite;
    assign is_ent = (i_paddr[11:8] == ENT_PAGE);
    assign ent_idx = i_paddr[7:5];
    assign ent_word = i_paddr[4:2];

    always_comb begin
        mapped = 1'b1;
        rd_word = 32'h0000_0000;
        if (i_paddr[1:0] != 2'h0) begin
            mapped = 1'b0;
        end else if (i_paddr == A_LIST_LEN) begin
            rd_word = {28'h0, list_len};
        end else if (i_paddr == A_STATUS) begin
            rd_word = {27'h0, o_vrd_use_default, o_vrd_hit, o_vrd_entry};
        end else if (i_paddr == A_SHUT) begin
            rd_word = {24'h0, o_port_disable};
        end else if (is_ent && (ent_word == W_CTRL0)) begin
            rd_word = ctrl0[ent_idx];
        end else if (is_ent && (ent_word == W_CTRL1)) begin
            rd_word = ctrl1[ent_idx];
        end else if (is_ent && (ent_word == W_SOURCE_HW_ADDRESS_FILTER_LO)) begin
            rd_word = source_hw_address_filter[ent_idx][31:0];
        end else if (is_ent && (ent_word == W_SOURCE_HW_ADDRESS_FILTER_HI)) begin
            rd_word = {16'h0, source_hw_address_filter[ent_idx][47:32]};
        end else if (is_ent && (ent_word == W_DEST_HW_ADDRESS_FILTER_LO)) begin
            rd_word = dest_hw_address_filter[ent_idx][31:0];
        end else if (is_ent && (ent_word == W_DEST_HW_ADDRESS_FILTER_HI)) begin
            rd_word = {16'h0, dest_hw_address_filter[ent_idx][47:32]};
        end else if (is_ent && (ent_word == W_COUNT)) begin
            rd_word = hit_count[ent_idx];
        end else begin
            mapped = 1'b0;
        end
    end

    // one wait state keeps read data and error straight from flops
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= apb_acc && !o_pready;
            if (apb_acc && !o_pready) begin
                o_prdata <= i_pwrite ? 32'h0000_0000 : rd_word;
                o_pslverr <= !mapped;
            end
        end
    end

    // configuration storage; entries reset to any/permit with no actions
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            list_len <= LIST_LEN_RST;
            for (int e = 0; e < NUM_ENTRIES; e++) begin
                ctrl0[e] <= 32'h0000_0000;
                ctrl1[e] <= 32'h0000_0000;
                source_hw_address_filter[e] <= 48'h0000_0000_0000;
                dest_hw_address_filter[e] <= 48'h0000_0000_0000;
            end
        end else if (apb_wr && mapped) begin
            if (i_paddr == A_LIST_LEN) begin
                list_len <= i_pwdata[3:0];
            end else if (is_ent && (ent_word == W_CTRL0)) begin
                ctrl0[ent_idx] <= i_pwdata;
            end else if (is_ent && (ent_word == W_CTRL1)) begin
                ctrl1[ent_idx] <= i_pwdata;
            end else if (is_ent && (ent_word == W_SOURCE_HW_ADDRESS_FILTER_LO)) begin
                source_hw_address_filter[ent_idx][31:0] <= i_pwdata;
            end else if (is_ent && (ent_word == W_SOURCE_HW_ADDRESS_FILTER_HI)) begin
                source_hw_address_filter[ent_idx][47:32] <= i_pwdata[15:0];
            end else if (is_ent && (ent_word == W_DEST_HW_ADDRESS_FILTER_LO)) begin
                dest_hw_address_filter[ent_idx][31:0] <= i_pwdata;
            end else if (is_ent && (ent_word == W_DEST_HW_ADDRESS_FILTER_HI)) begin
                dest_hw_address_filter[ent_idx][47:32] <= i_pwdata[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks on the verdict path and the APB answer timing
    property p_vrd_follows;
        i_frm_valid |=> o_vrd_valid && (o_vrd_port == $past(i_frm_port));
    endproperty
    a_vrd_follows: assert property (p_vrd_follows) else $error("verdict missing");

    property p_deny;
        i_frm_valid && any_hit && first_c0[F_DENY] |=> !o_vrd_permit && o_vrd_hit;
    endproperty
    a_deny: assert property (p_deny) else $error("denied frame permitted");

    property p_empty_list;
        i_frm_valid && (list_len == 4'h0) |=> o_vrd_use_default && !o_vrd_hit;
    endproperty
    a_empty_list: assert property (p_empty_list) else $error("empty list matched");

    property p_default;
        o_vrd_valid |-> (o_vrd_hit != o_vrd_use_default) && (o_vrd_hit || !o_vrd_copy);
    endproperty
    a_default: assert property (p_default) else $error("default and hit disagree");

    property p_shutdown;
        i_frm_valid && any_hit && first_c0[F_SHUT] |=> o_port_disable[$past(i_frm_port)];
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("port not disabled");

    property p_count;
        i_frm_valid && hit[0] && !(apb_wr && is_ent) |=>
            hit_count[0] == $past(hit_count[0]) + 32'h0000_0001;
    endproperty
    a_count: assert property (p_count) else $error("hit count not advanced");

    property p_arp_etype;
        (i_frm_ethtype == ETYPE_ARP) && (ctrl0[0][F_FTYPE +: 2] == FT_ETYPE) |-> !hit[0];
    endproperty
    a_arp_etype: assert property (p_arp_etype) else $error("ARP hit ethertype entry");

    property p_ip_etype;
        (i_frm_ethtype == ETYPE_IPV4) && (ctrl0[0][F_FTYPE +: 2] == FT_ETYPE) |-> !hit[0];
    endproperty
    a_ip_etype: assert property (p_ip_etype) else $error("IPv4 hit ethertype entry");

    property p_etype_min;
        (i_frm_ethtype < ETYPE_MIN) && (ctrl0[0][F_FTYPE +: 2] == FT_ETYPE) |-> !hit[0];
    endproperty
    a_etype_min: assert property (p_etype_min) else $error("length field hit ethertype");

    property p_apb_wait;
        i_psel && !i_penable |=> !o_pready ##1 o_pready;
    endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("APB answer timing wrong");

    // downstream applies the port default, so a miss must carry no stale actions
    property p_no_hit_quiet;
        i_frm_valid && !any_hit |=> !o_vrd_copy && !o_vrd_log && (o_vrd_rate_lim == 4'h0) &&
            (o_vrd_copy_port == 3'h0);
    endproperty
    a_no_hit_quiet: assert property (p_no_hit_quiet) else $error("actions without a hit");

    // slot 0 matching must win over every later slot
    property p_first_wins;
        i_frm_valid && hit[0] |=> o_vrd_hit && (o_vrd_entry == 3'h0);
    endproperty
    a_first_wins: assert property (p_first_wins) else $error("later entry won over slot 0");

    c_hit: cover property (i_frm_valid && any_hit ##1 o_vrd_permit);
    c_deny: cover property (o_vrd_valid && o_vrd_hit && !o_vrd_permit);
    c_default: cover property (o_vrd_valid && o_vrd_use_default);
    c_shutdown: cover property ($rose(|o_port_disable));
    c_copy: cover property (o_vrd_valid && o_vrd_copy && o_vrd_log);
endmodule
`default_nettype wire

// ==== hdl/ialc_pkg.sv ====
// Purpose: constants for the ingress access list classifier
// Assumes: one switch clock, APB register access, 8 ports, 8 list entries
// Notes: entry registers occupy 32-byte pages from ENT_PAGE upward
//
// Function
// - ingress selector matches any port, one port, or a policy 1 to 8
// - frame type is one of any, ethertype, ARP, IPv4; any accepts all
// - ethertype selection needs a length/type field of at least 0x0600
// - ARP selection matches only ARP; ARP never matches ethertype entries
// - IPv4 selection matches only IPv4; IPv4 never matches ethertype entries
// - matched entry action: permit forwards the frame, deny discards it
// - entry selects no policing or rate limiter 1 to 15
// - port copy enabled sends a duplicate to the configured port
// - logging enabled passes matching frames to the log path, which may drop
// - shutdown enabled disables the port the matching frame arrived on
// - per-entry readable hit counter increments once per frame on which that entry is the lowest matching slot
// - source address filter, only for ethertype or ARP: any or exact 48-bit
// - destination filter: any, group, all-ones, single, or exact 48-bit
// - VLAN filter: any or exact compare with configured ID 1 to 4095
// - priority filter: any or exact compare of the 3-bit tag priority
// - IPv4 protocol filter: any, specific number, ICMP, UDP or TCP
// - specific protocol compares the frame field against an 8-bit value
// - zero TTL setting rejects IPv4 frames with nonzero time-to-live
// - nonzero TTL setting accepts frames above zero; any ignores the field
// - a frame matching no entry takes its port default handling
package ialc_pkg;
    localparam int NUM_ENTRIES = 8;
    // register map, byte addresses
    localparam logic [11:0] A_LIST_LEN = 12'h000;
    localparam logic [11:0] A_STATUS = 12'h004;
    localparam logic [11:0] A_SHUT = 12'h008;
    localparam logic [3:0] ENT_PAGE = 4'h1;
    localparam logic [2:0] W_CTRL0 = 3'h0;
    localparam logic [2:0] W_CTRL1 = 3'h1;
    localparam logic [2:0] W_SOURCE_HW_ADDRESS_FILTER_LO = 3'h2;
    localparam logic [2:0] W_SOURCE_HW_ADDRESS_FILTER_HI = 3'h3;
    localparam logic [2:0] W_DEST_HW_ADDRESS_FILTER_LO = 3'h4;
    localparam logic [2:0] W_DEST_HW_ADDRESS_FILTER_HI = 3'h5;
    localparam logic [2:0] W_COUNT = 3'h6;
    localparam logic [3:0] LIST_LEN_RST = 4'h0;
    // control word 0 field positions
    localparam int F_ING_MODE = 0;
    localparam int F_ING_VAL = 2;
    localparam int F_FTYPE = 6;
    localparam int F_DENY = 8;
    localparam int F_RATE = 9;
    localparam int F_COPY_EN = 13;
    localparam int F_COPY_PORT = 14;
    localparam int F_LOG = 17;
    localparam int F_SHUT = 18;
    localparam int F_SOURCE_HW_ADDRESS_FILTER_SPEC = 19;
    localparam int F_DEST_HW_ADDRESS_FILTER_MODE = 20;
    // control word 1 field positions
    localparam int F_VID = 0;
    localparam int F_VID_SPEC = 12;
    localparam int F_PRI = 13;
    localparam int F_PRI_SPEC = 16;
    localparam int F_PROTO_MODE = 17;
    localparam int F_PROTO = 20;
    localparam int F_TTL_MODE = 28;
    // selector codes
    localparam logic [1:0] ING_ANY = 2'h0;
    localparam logic [1:0] ING_PORT = 2'h1;
    localparam logic [1:0] ING_POLICY = 2'h2;
    localparam logic [3:0] POLICY_MIN = 4'h1;
    localparam logic [3:0] POLICY_MAX = 4'h8;
    localparam logic [1:0] FT_ANY = 2'h0;
    localparam logic [1:0] FT_ETYPE = 2'h1;
    localparam logic [1:0] FT_ARP = 2'h2;
    localparam logic [1:0] FT_IPV4 = 2'h3;
    localparam logic [2:0] DM_ANY = 3'h0;
    localparam logic [2:0] DM_GROUP = 3'h1;
    localparam logic [2:0] DM_ALL_ONES = 3'h2;
    localparam logic [2:0] DM_SINGLE = 3'h3;
    localparam logic [2:0] DM_EXACT = 3'h4;
    localparam logic [2:0] PR_ANY = 3'h0;
    localparam logic [2:0] PR_SPEC = 3'h1;
    localparam logic [2:0] PR_ICMP = 3'h2;
    localparam logic [2:0] PR_UDP = 3'h3;
    localparam logic [2:0] PR_TCP = 3'h4;
    localparam logic [1:0] TTL_ANY = 2'h0;
    localparam logic [1:0] TTL_ZERO = 2'h1;
    localparam logic [1:0] TTL_NONZERO = 2'h2;
    // frame field values
    localparam logic [15:0] ETYPE_MIN = 16'h0600;
    localparam logic [15:0] ETYPE_ARP = 16'h0806;
    localparam logic [15:0] ETYPE_IPV4 = 16'h0800;
    localparam logic [7:0] PROTO_ICMP = 8'h01;
    localparam logic [7:0] PROTO_UDP = 8'h11;
    localparam logic [7:0] PROTO_TCP = 8'h06;
endpackage

// ==== test/ialc_far_end.sv ====
// Purpose: far-end model, port receive logic and forwarding engine
// Assumes: one descriptor a call, verdict one cycle after it is taken
// Notes: fields read inverted outside a descriptor so stale values never match
`timescale 1ns/10ps
`default_nettype none
module ialc_far_end (
    input wire logic i_clk,
    output logic o_frm_valid,
    output logic [149:0] o_desc,
    input wire logic i_vrd_valid,
    input wire logic [14:0] i_vrd,
    output logic [14:0] o_got
);
    initial begin
        o_frm_valid = 1'b0;
        o_desc = '0;
        o_got = '0;
    end
    ////////////////////////////////////////////////////////////////////////
    // one-cycle descriptor, then wait for the edge that shows the verdict
    task automatic send(input logic [149:0] d);
        @(posedge i_clk);
        o_frm_valid <= 1'b1;
        o_desc <= d;
        o_got <= 'x; // a missing verdict can never pass
        @(posedge i_clk);
        o_frm_valid <= 1'b0;
        o_desc <= ~d;
        @(posedge i_clk);
        @(negedge i_clk);
    endtask
    // forwarding side keeps the last verdict it was handed
    always @(posedge i_clk) begin
        if (i_vrd_valid === 1'b1) begin
            o_got <= i_vrd;
        end
    end
endmodule
`default_nettype wire

// ==== test/tb_ingress_access_list_classifier.sv ====
// Purpose: self-checking bench for the access list classifier
// Assumes: entry registers clear at reset
// Notes: verdict bits hit,default,permit,entry,rate,copy,copy port,log
`timescale 1ns/10ps
`default_nettype none
module tb_ingress_access_list_classifier;
    import ialc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] pa = '0;
    logic [31:0] pwd = '0;
    logic [31:0] prd;
    logic prdy, perr, fv, vv;
    logic [149:0] fd;
    logic [14:0] got;
    logic [2:0] vport;
    logic [7:0] pdis;
    logic [32:0] r;
    wire logic [14:0] v;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    always #20 clk = ~clk;
    ialc_top uut (.i_clk(clk), .i_reset_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr),
        .i_frm_valid(fv), .i_frm_port(fd[149:147]), .i_frm_policy(fd[146:143]),
        .i_frm_ethtype(fd[142:127]), .i_frm_source_hw_address_filter(fd[126:79]), .i_frm_dest_hw_address_filter(fd[78:31]),
        .i_frm_vid(fd[30:19]), .i_frm_pcp(fd[18:16]), .i_frm_proto(fd[15:8]), .i_frm_ttl(fd[7:0]),
        .o_vrd_valid(vv), .o_vrd_hit(v[14]), .o_vrd_use_default(v[13]), .o_vrd_permit(v[12]),
        .o_vrd_entry(v[11:9]), .o_vrd_rate_lim(v[8:5]), .o_vrd_copy(v[4]), .o_vrd_copy_port(v[3:1]),
        .o_vrd_log(v[0]), .o_vrd_port(vport), .o_port_disable(pdis));
    ialc_far_end fe (.i_clk(clk), .o_frm_valid(fv), .o_desc(fd), .i_vrd_valid(vv), .i_vrd(v), .o_got(got));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [32:0] g, input logic [32:0] e);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic test_done;
        $display("compared %0d, mismatched %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // apb transfer, result {pslverr, prdata} left in r
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (prdy !== 1'b1);
        r = {perr, prd};
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    function automatic logic [11:0] ea(input logic [2:0] e, input logic [2:0] w);
        return {ENT_PAGE, e, w, 2'b00};
    endfunction
    function automatic logic [149:0] dsc(input logic [2:0] p, input logic [15:0] e, input logic [47:0] dm,
        input logic [7:0] t);
        return {p, 4'h1, e, 48'h0A0B0C0D0E0F, dm, 12'h005, 3'h2, 8'h11, t};
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // empty list after reset: every frame takes its port default
    task automatic t_reset;
        apb(1'b0, A_LIST_LEN, 32'h00000000);
        chk(r, {29'h0, LIST_LEN_RST});
        fe.send(dsc(3'h6, ETYPE_IPV4, 48'h000000000001, 8'h40));
        chk(got & 15'h71FF, 15'h2000);
        chk(vport, 3'h6);
        $display("reset test done");
    endtask
    // ethertype selection at the 0x0600 boundary and against ARP and IPv4
    task automatic t_etype;
        logic [15:0] et [4] = '{16'h05FF, ETYPE_MIN, ETYPE_ARP, ETYPE_IPV4};
        apb(1'b1, A_LIST_LEN, 32'h00000001);
        apb(1'b1, ea(3'h0, W_CTRL0), 32'h00000140);
        for (int i = 0; i < 4; i++) begin
            fe.send(dsc(3'h0, et[i], 48'h000000000001, 8'h40));
            chk(got & (i == 1 ? 15'h7FFF : 15'h71FF), i == 1 ? 15'h4000 : 15'h2000);
        end
        $display("ethertype test done");
    endtask
    // port selector with every side action, counter, shutdown clear, hole
    task automatic t_actions;
        apb(1'b1, ea(3'h0, W_CTRL0), 32'h00077E0D);
        fe.send(dsc(3'h3, ETYPE_IPV4, 48'h000000000001, 8'h40));
        chk(got, 15'h51FB);
        chk(pdis, 8'h08);
        fe.send(dsc(3'h2, ETYPE_IPV4, 48'h000000000001, 8'h40));
        chk(got & 15'h71FF, 15'h2000);
        // one hit from the ethertype test plus the port 3 frame here
        apb(1'b0, ea(3'h0, W_COUNT), 32'h00000000);
        chk(r, 33'h000000002);
        apb(1'b1, A_SHUT, 32'h00000008);
        apb(1'b0, A_SHUT, 32'h00000000);
        chk(r, 33'h000000000);
        apb(1'b0, ea(3'h0, 3'h7), 32'h00000000);
        chk(r, 33'h100000000);
        $display("action test done");
    endtask
    // ttl zero and nonzero on entry 0, entry 1 catches what falls through
    task automatic t_order;
        apb(1'b1, A_LIST_LEN, 32'h00000002);
        apb(1'b1, ea(3'h0, W_CTRL0), 32'h000000C0);
        apb(1'b1, ea(3'h1, W_CTRL0), 32'h00000000);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, ea(3'h0, W_CTRL1), {2'b00, (i < 2) ? TTL_ZERO : TTL_NONZERO, 28'h0});
            fe.send(dsc(3'h1, ETYPE_IPV4, 48'h000000000001, i[0] ? 8'h00 : 8'h05));
            chk(got, (i == 1 || i == 2) ? 15'h5000 : 15'h5200);
        end
        $display("order test done");
    endtask
    // every destination filter mode against a broadcast frame
    task automatic t_dest_hw_address_filter;
        apb(1'b1, A_LIST_LEN, 32'h00000001);
        apb(1'b1, ea(3'h0, W_CTRL1), 32'h00000000);
        apb(1'b1, ea(3'h0, W_DEST_HW_ADDRESS_FILTER_LO), 32'hFFFFFFFF);
        apb(1'b1, ea(3'h0, W_DEST_HW_ADDRESS_FILTER_HI), 32'h0000FFFF);
        for (int m = 0; m < 5; m++) begin
            apb(1'b1, ea(3'h0, W_CTRL0), {9'h0, m[2:0], 20'h0});
            fe.send(dsc(3'h0, ETYPE_IPV4, 48'hFFFFFFFFFFFF, 8'h40));
            if (m[0] == 1'b0) chk(got, 15'h5000);
            else chk(got & 15'h71FF, 15'h2000);
        end
        $display("destination filter test done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    // a hang counts as a mismatch and ends the run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            test_done;
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_etype;
        t_actions;
        t_order;
        t_dest_hw_address_filter;
        test_done;
    end
endmodule
`default_nettype wire
